// ==== shared/cbcc_cfg_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface cbcc_cfg_if;
    import cbcc_pkg::*;
    logic earlyWrite;
    logic fastRead;
    logic [2:0] zoneWait;
    logic [1:0] zoneHold;
    logic [2:0] ioWait;
    logic [1:0] ioHold;
    logic busy;
    cbcc_kind_t lastKind;

    modport cfg (
        output earlyWrite, fastRead, zoneWait, zoneHold, ioWait, ioHold,
        input busy, lastKind
    );
    modport ctrl (
        input earlyWrite, fastRead, zoneWait, zoneHold, ioWait, ioHold,
        output busy, lastKind
    );
endinterface
`default_nettype wire

// ==== shared/cbcc_map.svh ====
// Behaviour
// - Timing per access comes from configuration registers.
// - Four cycle kinds: normal/fast read, early/late write.
// - Kind from direction, region and programmed styles.
// - Normal read two clocks, fast read one.
// - Reads are normal after reset.
// - Late write two clocks, early write three.
// - Writes are early after reset.
// - Wait cycles follow the address phase directly.
// - Hold cycles end the cycle, data kept driven.
// - Write-mode register readable, writable, resets to 07.
// - Bit 0 clear selects late, set selects early.
// - Zone 0 normal read waits one plus field.
`ifndef CBCC_MAP_SVH
`define CBCC_MAP_SVH

// Register addresses on the configuration port.
`define CBCC_WMODE_ADDR 16'hf900
`define CBCC_IOZONE_ADDR 16'hf902
`define CBCC_ZONE0_ADDR 16'hf904
`define CBCC_STATUS_ADDR 16'hf906

// Reset values and writable-bit masks.
`define CBCC_WMODE_RST 8'h07
`define CBCC_WMODE_MASK 8'h07
`define CBCC_IOZONE_RST 16'h069f
`define CBCC_IOZONE_MASK 16'h069f
`define CBCC_ZONE0_RST 16'h069f
`define CBCC_ZONE0_MASK 16'h0e9f

// Field positions.
`define CBCC_EWR_BIT 0
`define CBCC_WAIT_LSB 0
`define CBCC_WAIT_MSB 2
`define CBCC_HOLD_LSB 3
`define CBCC_HOLD_MSB 4
`define CBCC_FRE_BIT 11

// Address regions.
`define CBCC_ZONE0_LO 16'h0000
`define CBCC_ZONE0_HI 16'hbfff
`define CBCC_RAM_LO 16'he000
`define CBCC_RAM_HI 16'he7ff
`define CBCC_PORT_LO 16'hfb00
`define CBCC_PORT_HI 16'hfbff
`define CBCC_PERI_LO 16'hf000
`define CBCC_PERI_HI 16'hffff

// Timing counts in clock cycles.
`define CBCC_BASE_NREAD 5'd2
`define CBCC_BASE_FREAD 5'd1
`define CBCC_BASE_EWRITE 5'd3
`define CBCC_BASE_LWRITE 5'd2
`define CBCC_PERI_WAITS 4'h1
`define CBCC_ZONE0_FIXED_WAITS 4'h1

`endif

// ==== shared/cbcc_pkg.sv ====
package cbcc_pkg;

    // Bus cycle sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        CBCC_IDLE = 3'h0,
        CBCC_ADDR = 3'h1,
        CBCC_WAIT = 3'h3,
        CBCC_DATA = 3'h2,
        CBCC_EXTRA = 3'h6,
        CBCC_HOLD = 3'h7
    } cbcc_state_t;

    typedef enum logic [1:0] {
        CBCC_NREAD = 2'h0,
        CBCC_FREAD = 2'h1,
        CBCC_EWRITE = 2'h2,
        CBCC_LWRITE = 2'h3
    } cbcc_kind_t;

    typedef struct packed {
        cbcc_kind_t kind;
        logic [3:0] waits;
        logic [1:0] holds;
    } cbcc_timing_t;

    typedef struct packed {
        cbcc_state_t state;
        cbcc_kind_t kind;
        cbcc_kind_t lastKind;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [3:0] cnt;
        logic [1:0] holds;
        logic stall;
        logic done;
        logic [15:0] rdata;
        logic rdEn;
        logic wrEn;
        logic wdEn;
        logic [4:0] lenCnt;
        logic [4:0] expLen;
    } cbcc_ctl_t;

    typedef struct packed {
        logic [7:0] wmode;
        logic [15:0] ioZone;
        logic [15:0] zone0;
        logic [15:0] rdata;
    } cbcc_cfg_t;

endpackage

// ==== src/cbcc_cfg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cbcc_map.svh"
module cbcc_cfg_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    cbcc_cfg_if.cfg ifc
);
    import cbcc_pkg::*;

    cbcc_cfg_t st;
    cbcc_cfg_t next_st;

    // Writes keep only implemented bits, so reserved bits read back as zero.
    always_comb begin
        next_st = st;
        next_st.rdata = 16'h0000;
        if (regWr) begin
            case (regAddr)
                `CBCC_WMODE_ADDR: next_st.wmode = regWdata[7:0] & `CBCC_WMODE_MASK;
                `CBCC_IOZONE_ADDR: next_st.ioZone = regWdata & `CBCC_IOZONE_MASK;
                `CBCC_ZONE0_ADDR: next_st.zone0 = regWdata & `CBCC_ZONE0_MASK;
                default: next_st.wmode = st.wmode;
            endcase
        end
        // Read data stands for exactly one cycle; unmapped addresses read zero.
        if (regRd) begin
            case (regAddr)
                `CBCC_WMODE_ADDR: next_st.rdata = {8'h00, st.wmode};
                `CBCC_IOZONE_ADDR: next_st.rdata = st.ioZone;
                `CBCC_ZONE0_ADDR: next_st.rdata = st.zone0;
                `CBCC_STATUS_ADDR: next_st.rdata = {13'h0000, ifc.busy, ifc.lastKind};
                default: next_st.rdata = 16'h0000;
            endcase
        end
    end

    // Reset defaults give early writes and normal reads.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.wmode <= `CBCC_WMODE_RST;
            st.ioZone <= `CBCC_IOZONE_RST;
            st.zone0 <= `CBCC_ZONE0_RST;
            st.rdata <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    assign regRdata = st.rdata;
    assign ifc.earlyWrite = st.wmode[`CBCC_EWR_BIT];
    assign ifc.fastRead = st.zone0[`CBCC_FRE_BIT];
    assign ifc.zoneWait = st.zone0[`CBCC_WAIT_MSB:`CBCC_WAIT_LSB];
    assign ifc.zoneHold = st.zone0[`CBCC_HOLD_MSB:`CBCC_HOLD_LSB];
    assign ifc.ioWait = st.ioZone[`CBCC_WAIT_MSB:`CBCC_WAIT_LSB];
    assign ifc.ioHold = st.ioZone[`CBCC_HOLD_MSB:`CBCC_HOLD_LSB];

    wmode_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> st.wmode == `CBCC_WMODE_RST)
        else $error("Write-mode register did not reset to its default.");
    early_default_a: assert property (@(posedge clk) $rose(rst_n) |-> ifc.earlyWrite && !ifc.fastRead)
        else $error("Reset did not select early writes and normal reads.");
    wmode_rdback_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWr && regAddr == `CBCC_WMODE_ADDR) ##1 (regRd && regAddr == `CBCC_WMODE_ADDR && !regWr)
        |=> regRdata == ($past(regWdata, 2) & {8'h00, `CBCC_WMODE_MASK}))
        else $error("Write-mode register did not read back the written value.");
    ewr_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regWr && regAddr == `CBCC_WMODE_ADDR) |=> ifc.earlyWrite == $past(regWdata[0]))
        else $error("Early-write select does not follow bit 0.");
endmodule
`default_nettype wire

// ==== src/cbcc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cbcc_map.svh"
module cbcc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic coreReq,
    input wire logic coreWrite,
    input wire logic [15:0] coreAddr,
    input wire logic [15:0] coreWdata,
    output logic coreStall,
    output logic coreDone,
    output logic [15:0] coreRdata,
    output logic [15:0] busAddr,
    output logic [15:0] busWdata,
    output logic busRdEn,
    output logic busWrEn,
    output logic busWdataEn,
    input wire logic [15:0] busRdata,
    output cbcc_pkg::cbcc_kind_t busKind
);
    import cbcc_pkg::*;

    cbcc_cfg_if ifc ();
    cbcc_ctl_t st;
    cbcc_ctl_t next_st;

    // The register file supplies the timing fields the sequencer reads.
    cbcc_cfg_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .regRdata(regRdata),
        .ifc(ifc.cfg)
    );

    // Base length of each cycle kind before waits and holds are added.
    function automatic logic [4:0] cbccBase(input cbcc_kind_t kind);
        case (kind)
            CBCC_NREAD: cbccBase = `CBCC_BASE_NREAD;
            CBCC_FREAD: cbccBase = `CBCC_BASE_FREAD;
            CBCC_EWRITE: cbccBase = `CBCC_BASE_EWRITE;
            default: cbccBase = `CBCC_BASE_LWRITE;
        endcase
    endfunction

    function automatic logic cbccIn(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        cbccIn = (a >= lo) && (a <= hi);
    endfunction

    // Picks kind, waits and holds from direction, region and settings.
    // Only zone 0 honours fast reads; zone 0 without fast reads and the port region take programmed waits and holds, the rest fixed timing.
    function automatic cbcc_timing_t cbccTiming(
        input logic [15:0] a,
        input logic wr,
        input logic early,
        input logic fast,
        input logic [2:0] zWait,
        input logic [1:0] zHold,
        input logic [2:0] pWait,
        input logic [1:0] pHold
    );
        cbcc_timing_t t;
        t.kind = wr ? (early ? CBCC_EWRITE : CBCC_LWRITE) : CBCC_NREAD;
        t.waits = 4'h0;
        t.holds = 2'h0;
        if (cbccIn(a, `CBCC_ZONE0_LO, `CBCC_ZONE0_HI)) begin
            if (fast) begin
                t.kind = wr ? t.kind : CBCC_FREAD;
                t.waits = wr ? `CBCC_ZONE0_FIXED_WAITS : 4'h0;
            end else begin
                t.waits = {1'b0, zWait} + `CBCC_ZONE0_FIXED_WAITS;
                t.holds = zHold;
            end
        end else if (cbccIn(a, `CBCC_RAM_LO, `CBCC_RAM_HI)) begin
            t.waits = 4'h0;
        end else if (cbccIn(a, `CBCC_PORT_LO, `CBCC_PORT_HI)) begin
            t.waits = {1'b0, pWait};
            t.holds = pHold;
        end else if (cbccIn(a, `CBCC_PERI_LO, `CBCC_PERI_HI)) begin
            t.waits = `CBCC_PERI_WAITS;
        end
        return t;
    endfunction

    // Sequencer: address phase, waits, data phase, early-write extra cycle, holds.
    always_comb begin
        cbcc_timing_t t;
        logic finish;
        t = cbccTiming(coreAddr, coreWrite, ifc.earlyWrite, ifc.fastRead,
            ifc.zoneWait, ifc.zoneHold, ifc.ioWait, ifc.ioHold);
        finish = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        if (st.state != CBCC_IDLE) begin
            next_st.lenCnt = st.lenCnt + 5'd1;
        end
        case (st.state)
            CBCC_IDLE: begin
                if (coreReq) begin
                    next_st.state = CBCC_ADDR;
                    next_st.kind = t.kind;
                    next_st.write = coreWrite;
                    next_st.addr = coreAddr;
                    next_st.wdata = coreWdata;
                    next_st.cnt = t.waits;
                    next_st.holds = t.holds;
                    next_st.stall = 1'b1;
                    next_st.lenCnt = 5'd0;
                    next_st.expLen = cbccBase(t.kind) + {1'b0, t.waits} + {3'h0, t.holds};
                end
            end
            CBCC_ADDR: begin
                if (st.kind == CBCC_FREAD) begin
                    next_st.rdata = busRdata;
                    finish = 1'b1;
                end else if (st.cnt != 4'h0) begin
                    next_st.state = CBCC_WAIT;
                end else begin
                    next_st.state = CBCC_DATA;
                end
            end
            CBCC_WAIT: begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h1) begin
                    next_st.state = CBCC_DATA;
                end
            end
            CBCC_DATA: begin
                if (!st.write) begin
                    next_st.rdata = busRdata;
                end
                if (st.kind == CBCC_EWRITE) begin
                    next_st.state = CBCC_EXTRA;
                end else if (st.holds != 2'h0) begin
                    next_st.state = CBCC_HOLD;
                end else begin
                    finish = 1'b1;
                end
            end
            CBCC_EXTRA: begin
                if (st.holds != 2'h0) begin
                    next_st.state = CBCC_HOLD;
                end else begin
                    finish = 1'b1;
                end
            end
            CBCC_HOLD: begin
                next_st.holds = st.holds - 2'h1;
                if (st.holds == 2'h1) begin
                    finish = 1'b1;
                end
            end
            default: begin
                next_st.state = CBCC_IDLE;
                next_st.stall = 1'b0;
            end
        endcase
        // The stall drops only together with completion.
        if (finish) begin
            next_st.state = CBCC_IDLE;
            next_st.stall = 1'b0;
            next_st.done = 1'b1;
            next_st.lastKind = st.kind;
        end
        // Strobes are decoded from the next state so every pin leaves a flop.
        // Early writes raise the write strobe after the address phase and keep it
        // through the extra cycle, which is why they cost one clock more.
        next_st.rdEn = !next_st.write && (next_st.state inside {CBCC_ADDR, CBCC_WAIT, CBCC_DATA});
        next_st.wdEn = next_st.write && (next_st.state != CBCC_IDLE);
        next_st.wrEn = next_st.write && ((next_st.state == CBCC_DATA) ||
            ((next_st.kind == CBCC_EWRITE) && (next_st.state inside {CBCC_WAIT, CBCC_EXTRA})));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{state: CBCC_IDLE, kind: CBCC_NREAD, lastKind: CBCC_NREAD,
                addr: 16'h0000, wdata: 16'h0000, rdata: 16'h0000, cnt: 4'h0,
                holds: 2'h0, lenCnt: 5'h00, expLen: 5'h00, default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign coreStall = st.stall;
    assign coreDone = st.done;
    assign coreRdata = st.rdata;
    assign busAddr = st.addr;
    assign busWdata = st.wdata;
    assign busRdEn = st.rdEn;
    assign busWrEn = st.wrEn;
    assign busWdataEn = st.wdEn;
    assign busKind = st.kind;
    assign ifc.busy = st.stall;
    assign ifc.lastKind = st.lastKind;

    // Checks on cycle lengths, order of phases and the core stall.
    logic takeNow;
    assign takeNow = coreReq && (st.state == CBCC_IDLE);

    cycle_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(coreDone) |-> ($past(st.lenCnt) + 5'd1) == $past(st.expLen))
        else $error("Bus cycle length differs from base plus waits plus holds.");
    fast_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state == CBCC_ADDR && st.kind == CBCC_FREAD) |=> coreDone && st.state == CBCC_IDLE)
        else $error("Fast read did not complete in one clock.");
    late_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state == CBCC_ADDR && st.kind == CBCC_LWRITE && st.cnt == 4'h0 && st.holds == 2'h0)
        |=> st.state == CBCC_DATA ##1 coreDone)
        else $error("Late write without extras did not take two clocks.");
    early_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state == CBCC_ADDR && st.kind == CBCC_EWRITE && st.cnt == 4'h0 && st.holds == 2'h0)
        |=> st.state == CBCC_DATA ##1 st.state == CBCC_EXTRA ##1 coreDone)
        else $error("Early write without extras did not take three clocks.");
    write_kind_a: assert property (@(posedge clk) disable iff (!rst_n)
        (takeNow && coreWrite) |=> st.kind == ($past(ifc.earlyWrite) ? CBCC_EWRITE : CBCC_LWRITE))
        else $error("Write kind does not follow the early-write select.");
    zone0_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        (takeNow && !coreWrite && !ifc.fastRead && coreAddr <= `CBCC_ZONE0_HI)
        |=> st.cnt == {1'b0, $past(ifc.zoneWait)} + 4'h1)
        else $error("Zone 0 normal read wait count is wrong.");
    wait_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state == CBCC_WAIT) |-> $past(st.state) inside {CBCC_ADDR, CBCC_WAIT})
        else $error("Wait cycle did not follow the address phase.");
    hold_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state == CBCC_HOLD && st.write) |-> busWdataEn && $stable(busWdata) && $stable(busAddr))
        else $error("Write data not held during hold cycle.");
    core_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.state != CBCC_IDLE) |-> coreStall && !coreDone)
        else $error("Core not stalled during a bus cycle.");
    stall_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(coreStall) |-> coreDone)
        else $error("Stall released without completion.");

    fast_read_c: cover property (@(posedge clk) disable iff (!rst_n)
        coreDone && st.lastKind == CBCC_FREAD);
    early_write_c: cover property (@(posedge clk) disable iff (!rst_n)
        coreDone && st.lastKind == CBCC_EWRITE);
    hold_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
        st.state == CBCC_HOLD && st.write);
    max_wait_c: cover property (@(posedge clk) disable iff (!rst_n)
        st.state == CBCC_WAIT && st.cnt == 4'h8);
endmodule
`default_nettype wire

// ==== tb/cbcc_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cbcc_mem_model #(
    parameter logic [15:0] FILL = 16'ha5c3
) (
    input wire logic clk,
    input wire logic [15:0] busAddr,
    input wire logic [15:0] busWdata,
    input wire logic busRdEn,
    input wire logic busWrEn,
    input wire logic busWdataEn,
    output logic [15:0] busRdata
);
    logic [15:0] mem [logic [15:0]];
    logic [15:0] junk = 16'h3c3c;

    // Memory takes write data only while both the strobe and the data enable are up.
    // The junk word flips every rising clock edge so an unqualified sample never looks like real data.
    always @(posedge clk) begin
        if (busWrEn === 1'b1 && busWdataEn === 1'b1) begin
            mem[busAddr] = busWdata;
        end
        junk <= ~junk;
    end

    // Read data answer in the same clock; unwritten words return a fill pattern.
    always @* begin
        if (busRdEn === 1'b1) begin
            busRdata = mem.exists(busAddr) ? mem[busAddr] : (busAddr ^ FILL);
        end else begin
            busRdata = junk;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cbcc_map.svh"
module tb;
    import cbcc_pkg::*;
    localparam logic [15:0] FILL = 16'ha5c3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic coreReq = 1'b0;
    logic coreWrite = 1'b0;
    logic [15:0] coreAddr = 16'h0000;
    logic [15:0] coreWdata = 16'h0000;
    logic coreStall, coreDone, busRdEn, busWrEn, busWdataEn;
    logic [15:0] coreRdata, busAddr, busWdata, busRdata;
    cbcc_kind_t busKind;
    integer seed = 32'h2f84bded;
    int errorCnt = 0;
    int testsRun = 0;
    logic early_write_select, fre;
    logic [2:0] zW, pW;
    logic [1:0] zH, pH;
    logic [15:0] shadow [logic [15:0]];
    logic [15:0] bases [6] = '{16'h0000, 16'hbf00, 16'he000, 16'hfb00, 16'hf100, 16'hc000};

    always #50 clk = ~clk;

    cbcc_top DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .coreReq(coreReq), .coreWrite(coreWrite),
        .coreAddr(coreAddr), .coreWdata(coreWdata), .coreStall(coreStall), .coreDone(coreDone),
        .coreRdata(coreRdata), .busAddr(busAddr), .busWdata(busWdata), .busRdEn(busRdEn),
        .busWrEn(busWrEn), .busWdataEn(busWdataEn), .busRdata(busRdata), .busKind(busKind));

    cbcc_mem_model #(.FILL(FILL)) farSide (.clk(clk), .busAddr(busAddr), .busWdata(busWdata),
        .busRdEn(busRdEn), .busWrEn(busWrEn), .busWdataEn(busWdataEn), .busRdata(busRdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Kind and length of a bus cycle, worked out from the programmed timing.
    function automatic logic [6:0] predict(input logic [15:0] a, input logic wr);
        cbcc_kind_t k;
        logic [4:0] len;
        k = wr ? (early_write_select ? CBCC_EWRITE : CBCC_LWRITE) : CBCC_NREAD;
        len = (wr && early_write_select) ? 5'd3 : 5'd2;
        if (a <= 16'hbfff) begin
            if (!wr && fre) begin
                k = CBCC_FREAD;
                len = 5'd1;
            end else if (wr && fre) begin
                len = len + 5'd1;
            end else begin
                len = len + 5'd1 + 5'(zW) + 5'(zH);
            end
        end else if (a >= 16'hfb00 && a <= 16'hfbff) begin
            len = len + 5'(pW) + 5'(pH);
        end else if (a >= 16'hf000) begin
            len = len + 5'd1;
        end
        return {k, len};
    endfunction

    task automatic regWrite(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic regCheck(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check(regRdata, e);
    endtask

    task automatic cfgSet(input logic e, input logic f, input logic [2:0] zw, input logic [1:0] zh,
                          input logic [2:0] pw, input logic [1:0] ph);
        logic [15:0] z;
        early_write_select = e;
        fre = f;
        zW = zw;
        zH = zh;
        pW = pw;
        pH = ph;
        z = {4'h0, f, 2'b11, 1'b0, 1'b1, 2'b00, zh, zw};
        regWrite(16'hf900, {13'h0, 2'b11, e});
        regWrite(16'hf904, z);
        regWrite(16'hf902, {5'h00, 2'b11, 1'b0, 1'b1, 2'b00, ph, pw});
        regCheck(16'hf904, z);
    endtask

    // Address and write data fields are scrambled after the take edge, so a unit that
    // fails to latch them shows up on the bus.
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
        logic [6:0] p;
        int n;
        int wrCnt;
        p = predict(a, wr);
        n = 0;
        wrCnt = 0;
        @(posedge clk);
        coreReq <= 1'b1;
        coreWrite <= wr;
        coreAddr <= a;
        coreWdata <= d;
        @(posedge clk);
        coreReq <= 1'b0;
        coreAddr <= ~a;
        coreWdata <= ~d;
        #1;
        while (coreDone !== 1'b1 && n < 40) begin
            check(coreStall, 1'b1);
            check(busAddr, a);
            if (wr) check({busWdataEn, busWdata}, {1'b1, d});
            else if (n == 0) check(busRdEn, 1'b1);
            if (busWrEn === 1'b1) wrCnt++;
            @(posedge clk);
            #1;
            n++;
        end
        check(n, p[4:0]);
        check(busKind, p[6:5]);
        check(coreStall, 1'b0);
        if (wr && a >= 16'he000 && a <= 16'he7ff) check(wrCnt, early_write_select ? 2 : 1);
        if (wr) shadow[a] = d;
        else check(coreRdata, shadow.exists(a) ? shadow[a] : (a ^ FILL));
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // A full run needs well under ten thousand cycles; this margin only catches a hang.
    initial begin
        #(40000 * 100);
        errorCnt++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        logic [15:0] a;
        {early_write_select, fre, zW, zH, pW, pH} = {1'b1, 1'b0, 3'h7, 2'h3, 3'h7, 2'h3};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        regCheck(16'hf900, 16'h0007);
        regCheck(16'hf902, 16'h069f);
        regCheck(16'hf904, 16'h069f);
        regCheck(16'hf910, 16'h0000);
        access(1'b0, 16'h0100, 16'h0000);
        access(1'b1, 16'he010, 16'h1234);
        regCheck(16'hf906, {13'h0, 1'b0, CBCC_EWRITE});
        regWrite(16'hf910, 16'hffff);
        regWrite(16'hf906, 16'hffff);
        // Write and read back with no idle cycle between the strobes, the tightest legal spacing.
        @(posedge clk);
        regAddr <= 16'hf900;
        regWdata <= 16'h0006;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check(regRdata, 16'h0006);
        regCheck(16'hf906, {13'h0, 1'b0, CBCC_EWRITE});
        early_write_select = 1'b0;
        access(1'b1, 16'he010, 16'h5678);
        access(1'b0, 16'he010, 16'h0000);
        cfgSet(1'b0, 1'b1, 3'h0, 2'h0, 3'h0, 2'h0);
        access(1'b0, 16'h0200, 16'h0000);
        access(1'b1, 16'h0200, 16'hbeef);
        // Random traffic over every region with timing reprogrammed now and then.
        repeat (160) begin
            r = $random(seed);
            if (r[26:24] == 3'h0) cfgSet(r[0], r[1], r[4:2], r[6:5], r[9:7], r[11:10]);
            r = $random(seed);
            a = bases[r[18:16] % 6] | {8'h00, r[7:1], 1'b0};
            access(r[20], a, r[31:16]);
        end
        conclude();
    end
endmodule
`default_nettype wire
